// ==== common/hsr_regs.vh ====
// Constants for the high-speed redriver mode controller
`ifndef HSR_REGS_VH
`define HSR_REGS_VH

// Timing figures in microseconds, clock period in nanoseconds
`define HSR_CLK_NS 100'd10
`define HSR_US_NS 10'd1000
`define HSR_CHIRP_MIN_US 18
`define HSR_CHIRP_MAX_US 128
`define HSR_RST_PW_US 100
`define HSR_READY_US 500
// Cycle counts: least times round up, longest round down
`define HSR_CHIRP_MIN_CYC ((`HSR_CHIRP_MIN_US*1000+9)/10)
`define HSR_CHIRP_MAX_CYC ((`HSR_CHIRP_MAX_US*1000)/10)
`define HSR_RST_PW_CYC ((`HSR_RST_PW_US*1000+9)/10)
`define HSR_READY_CYC ((`HSR_READY_US*1000)/10)
// Timebase width: one microsecond tick from a divider
`define HSR_TICK_DIV 7'd99
`define HSR_CNT_W 16

// Strap decode codes from the resistor-sensing front end
`define HSR_STRAP_LVL0 2'h0
`define HSR_STRAP_LVL1 2'h1
`define HSR_STRAP_LVL2 2'h2
`define HSR_STRAP_OPEN 2'h3
`define HSR_BOOST_DEFAULT 2'h3

// Line states reported by the analog front end
`define HSR_LINE_SE0 2'h0
`define HSR_LINE_J 2'h1
`define HSR_LINE_K 2'h2
`define HSR_LINE_SE1 2'h3

`endif

// ==== design/hsr_ctrl.v ====
// Mode and flag control for a high-speed USB redriver
// Notes on behaviour
// - Boost strap captured once after reset release
// - Open strap selects boost level three
// - Strap resistor range decodes to two-bit level
// - One level drives edge and DC boost
// - HS-active flag driven as output after reset
// - Fixture then test packet raises HS-active
// - Squelch after good handshake raises HS-active
// - Good handshake: chirp J then K, 18-128us
// - Low disable input holds reset and shutdown
// - Pull-up detected from unconnected raises attach
// - Disconnect clears attach flag
// - Attach pin undriven while disabled
// - Disable low 100us recognised as valid reset
// - Ready within 500us after disable release
// - LS/FS: attach high, HS-active low, no boost
// - HS mode: boost on, both flags high
// - Compliance mode: attach low, HS-active high
// - Disable low 100us in HS enters compliance mode
`timescale 1ns/1ps
`include "hsr_regs.vh"

module hsr_ctrl (
  input wire i_mclk,
  input wire i_sys_rst,
  input wire i_disable_n_input,
  input wire [1:0] i_boost_level_strap,
  input wire i_pullup_seen,
  input wire i_disconnect_seen,
  input wire i_fixture_seen,
  input wire i_test_packet_seen,
  input wire i_squelch,
  input wire i_bus_reset,
  input wire [1:0] i_line_state,
  output reg o_attach_flag,
  output reg o_attach_flag_oe_n,
  output reg o_hs_active_flag,
  output reg o_hs_active_flag_oe_n,
  output reg o_comp_enable,
  output reg [1:0] o_edge_boost,
  output reg [1:0] o_dc_boost,
  output reg o_ready
);

  localparam ST_OFF = 7'b000_0001;
  localparam ST_WAKE = 7'b000_0010;
  localparam ST_IDLE = 7'b000_0100;
  localparam ST_FIXT = 7'b000_1000;
  localparam ST_FS = 7'b001_0000;
  localparam ST_HS = 7'b010_0000;
  localparam ST_COMP = 7'b100_0000;

  localparam integer CHIRP_MIN_I = `HSR_CHIRP_MIN_CYC;
  localparam integer CHIRP_MAX_I = `HSR_CHIRP_MAX_CYC;
  localparam integer RST_PW_I = `HSR_RST_PW_CYC;
  localparam integer READY_I = `HSR_READY_CYC;
  localparam [15:0] CHIRP_MIN = CHIRP_MIN_I[15:0];
  localparam [15:0] CHIRP_MAX = CHIRP_MAX_I[15:0];
  localparam [15:0] RST_PW = RST_PW_I[15:0];
  localparam [15:0] READY_CYC = READY_I[15:0];
  // Settling well inside the ready limit
  localparam [15:0] WAKE_CYC = 16'h0100;

  // Chirp handshake tracker
  localparam HS_WAIT = 4'b0001;
  localparam HS_J = 4'b0010;
  localparam HS_K = 4'b0100;
  localparam HS_GOOD = 4'b1000;

  reg [6:0] state;
  reg [6:0] next_state;
  reg [3:0] hsk;
  reg [15:0] chirp_cnt;
  reg [15:0] low_cnt;
  reg [15:0] wake_cnt;
  reg pw_valid;
  reg was_hs;
  reg [1:0] boost;
  reg strap_taken;
  wire chirp_ok;

  function [1:0] strap_decode;
    input [1:0] code;
    begin
      case (code)
        `HSR_STRAP_LVL0: strap_decode = 2'h0;
        `HSR_STRAP_LVL1: strap_decode = 2'h1;
        `HSR_STRAP_LVL2: strap_decode = 2'h2;
        default: strap_decode = `HSR_BOOST_DEFAULT;
      endcase
    end
  endfunction

  assign chirp_ok = (chirp_cnt >= CHIRP_MIN) && (chirp_cnt <= CHIRP_MAX);

  // Low-pulse width measured while disabled; kept across the disable
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      low_cnt <= 16'h0000;
      pw_valid <= 1'b0;
      was_hs <= 1'b0;
    end else if (!i_disable_n_input) begin
      if (low_cnt != 16'hffff)
        low_cnt <= low_cnt + 16'h0001;
      if (low_cnt >= RST_PW - 16'h0001)
        pw_valid <= 1'b1;
      if (state == ST_HS)
        was_hs <= 1'b1;
    end else begin
      low_cnt <= 16'h0000;
      if (state == ST_WAKE && wake_cnt == 16'h0000) begin
        pw_valid <= 1'b0;
        was_hs <= 1'b0;
      end
    end
  end

  // Strap caught once after release, ignored thereafter
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      boost <= `HSR_BOOST_DEFAULT;
      strap_taken <= 1'b0;
    end else if (!i_disable_n_input) begin
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      boost <= strap_decode(i_boost_level_strap);
      strap_taken <= 1'b1;
    end
  end

  // Handshake tracker; squelch only counts after a full J-K pair
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hsk <= HS_WAIT;
      chirp_cnt <= 16'h0000;
    end else if (!i_disable_n_input || state != ST_FS) begin
      hsk <= HS_WAIT;
      chirp_cnt <= 16'h0000;
    end else begin
      case (hsk)
        HS_WAIT: begin
          // Entry edge is the first J cycle, so J and K count alike
          chirp_cnt <= 16'h0001;
          if (i_bus_reset && i_line_state == `HSR_LINE_J)
            hsk <= HS_J;
        end
        HS_J: begin
          if (i_line_state == `HSR_LINE_J) begin
            if (chirp_cnt != 16'hffff)
              chirp_cnt <= chirp_cnt + 16'h0001;
          end else if (i_line_state == `HSR_LINE_K && chirp_ok) begin
            hsk <= HS_K;
            chirp_cnt <= 16'h0001;
          end else
            hsk <= HS_WAIT;
        end
        HS_K: begin
          if (i_line_state == `HSR_LINE_K) begin
            if (chirp_cnt != 16'hffff)
              chirp_cnt <= chirp_cnt + 16'h0001;
          end else if (chirp_ok)
            hsk <= HS_GOOD;
          else
            hsk <= HS_WAIT;
        end
        HS_GOOD: hsk <= HS_GOOD;
        default: hsk <= HS_WAIT;
      endcase
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_OFF:
        if (i_disable_n_input)
          next_state = ST_WAKE;
      ST_WAKE:
        if (wake_cnt == 16'h0000) begin
          if (pw_valid && was_hs)
            next_state = ST_COMP;
          else
            next_state = ST_IDLE;
        end
      ST_IDLE:
        if (i_fixture_seen)
          next_state = ST_FIXT;
        else if (i_pullup_seen)
          next_state = ST_FS;
      ST_FIXT:
        if (i_test_packet_seen)
          next_state = ST_COMP;
        else if (!i_fixture_seen)
          next_state = ST_IDLE;
      ST_FS:
        if (i_disconnect_seen)
          next_state = ST_IDLE;
        else if (hsk == HS_GOOD && i_squelch)
          next_state = ST_HS;
      ST_HS:
        if (i_disconnect_seen)
          next_state = ST_IDLE;
      ST_COMP:
        next_state = ST_COMP;
      default: next_state = ST_OFF;
    endcase
  end

  // Wake countdown stays far below the ready limit
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= ST_OFF;
      wake_cnt <= 16'h0000;
    end else if (!i_disable_n_input) begin
      state <= ST_OFF;
      wake_cnt <= (WAKE_CYC < READY_CYC) ? WAKE_CYC : READY_CYC;
    end else begin
      state <= next_state;
      if (state == ST_WAKE && wake_cnt != 16'h0000)
        wake_cnt <= wake_cnt - 16'h0001;
    end
  end

  // Registered pin drive; flags cleared and undriven in shutdown
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_attach_flag <= 1'b0;
      o_attach_flag_oe_n <= 1'b1;
      o_hs_active_flag <= 1'b0;
      o_hs_active_flag_oe_n <= 1'b1;
      o_comp_enable <= 1'b0;
      o_edge_boost <= 2'h0;
      o_dc_boost <= 2'h0;
      o_ready <= 1'b0;
    end else if (!i_disable_n_input || next_state == ST_OFF) begin
      o_attach_flag <= 1'b0;
      o_attach_flag_oe_n <= 1'b1;
      o_hs_active_flag <= 1'b0;
      o_hs_active_flag_oe_n <= 1'b1;
      o_comp_enable <= 1'b0;
      o_edge_boost <= 2'h0;
      o_dc_boost <= 2'h0;
      o_ready <= 1'b0;
    end else begin
      o_attach_flag_oe_n <= 1'b0;
      o_hs_active_flag_oe_n <= 1'b0;
      o_ready <= (next_state != ST_WAKE);
      o_attach_flag <= (next_state == ST_FS) ||
                       (next_state == ST_HS);
      o_hs_active_flag <= (next_state == ST_HS) ||
                          (next_state == ST_COMP);
      o_comp_enable <= (next_state == ST_HS) ||
                       (next_state == ST_COMP);
      o_edge_boost <= (next_state == ST_HS || next_state == ST_COMP) ?
                      boost : 2'h0;
      o_dc_boost <= (next_state == ST_HS || next_state == ST_COMP) ?
                    boost : 2'h0;
    end
  end

endmodule // hsr_ctrl

// ==== testbench/hsr_ctrl_assertions.sv ====
// Port-level assertions for the redriver mode controller
`timescale 1ns/1ps
module hsr_ctrl_checker (
  input wire i_mclk,
  input wire i_sys_rst,
  input wire i_disable_n_input,
  input wire i_pullup_seen,
  input wire i_disconnect_seen,
  input wire o_attach_flag,
  input wire o_attach_flag_oe_n,
  input wire o_hs_active_flag,
  input wire o_hs_active_flag_oe_n,
  input wire o_comp_enable,
  input wire [1:0] o_edge_boost,
  input wire [1:0] o_dc_boost,
  input wire o_ready
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  // Two low samples so the one-edge shutdown lag is covered
  sequence s_held_off;
    !i_disable_n_input [*2];
  endsequence
  sequence s_wake;
    $rose(i_disable_n_input);
  endsequence
  shutdown_flags_a: assert property (s_held_off |-> o_attach_flag_oe_n &&
    !o_attach_flag && !o_hs_active_flag && !o_comp_enable) else $error("shutdown flags");
  boost_pair_a: assert property (o_edge_boost == o_dc_boost)
    else $error("boost mismatch");
  boost_off_a: assert property (!o_comp_enable |-> o_edge_boost == 2'h0)
    else $error("boost without comp");
  hs_comp_a: assert property (o_hs_active_flag |-> o_comp_enable)
    else $error("hs without comp");
  fs_no_comp_a: assert property (o_attach_flag && !o_hs_active_flag |->
    !o_comp_enable) else $error("fs with comp");
  attach_cause_a: assert property ($rose(o_attach_flag) |->
    $past(i_pullup_seen)) else $error("attach without pullup");
  detach_a: assert property (o_attach_flag && i_disconnect_seen &&
    i_disable_n_input |=> !o_attach_flag) else $error("detach late");
  hs_pin_a: assert property (o_ready |-> !o_hs_active_flag_oe_n)
    else $error("hs pin undriven");
  wake_time_a: assert property (s_wake |-> ##[1:300] o_ready)
    else $error("ready late");
endmodule // hsr_ctrl_checker

bind hsr_ctrl hsr_ctrl_checker u_chk (.i_mclk(i_mclk),
  .i_sys_rst(i_sys_rst), .i_disable_n_input(i_disable_n_input),
  .i_pullup_seen(i_pullup_seen), .i_disconnect_seen(i_disconnect_seen),
  .o_attach_flag(o_attach_flag), .o_attach_flag_oe_n(o_attach_flag_oe_n),
  .o_hs_active_flag(o_hs_active_flag),
  .o_hs_active_flag_oe_n(o_hs_active_flag_oe_n),
  .o_comp_enable(o_comp_enable), .o_edge_boost(o_edge_boost),
  .o_dc_boost(o_dc_boost), .o_ready(o_ready));

// ==== testbench/hsr_usb_peer.sv ====
// Transceiver model: bus reset, chirp pair and squelch
`timescale 1ns/1ps
`include "hsr_regs.vh"
module hsr_usb_peer (
  input wire i_mclk,
  output reg o_squelch = 1'h0,
  output reg o_bus_reset = 1'h0,
  output reg [1:0] o_line_state = 2'h0
);
  // Chirp lengths in cycles; callers pick prompt or slow peers
  task chirp(input integer j, input integer k);
    o_bus_reset <= 1'h1;
    o_line_state <= `HSR_LINE_J;
    repeat (j) @(posedge i_mclk);
    o_line_state <= `HSR_LINE_K;
    repeat (k) @(posedge i_mclk);
    o_line_state <= `HSR_LINE_SE0;
    o_bus_reset <= 1'h0;
    @(posedge i_mclk);
    o_squelch <= 1'h1;
    @(posedge i_mclk);
  endtask
endmodule // hsr_usb_peer

// ==== testbench/test_hsr_ctrl.sv ====
// Self-checking bench for the redriver mode controller
`timescale 1ns/1ps
module test_hsr_ctrl;
  reg i_mclk = 1'h0, i_sys_rst = 1'h1, i_disable_n_input = 1'h0;
  reg i_pullup_seen = 1'h0, i_disconnect_seen = 1'h0, smp = 1'h0;
  reg i_fixture_seen = 1'h0, i_test_packet_seen = 1'h0;
  reg [1:0] i_boost_level_strap = 2'h0, lvl;
  wire i_squelch, i_bus_reset, o_attach_flag, o_attach_flag_oe_n;
  wire o_hs_active_flag, o_hs_active_flag_oe_n, o_comp_enable, o_ready;
  wire [1:0] i_line_state, o_edge_boost, o_dc_boost;
  reg [8:0] q[$];
  reg [16:0] r = 17'h1_721d;
  integer failures = 0, n_checks = 0, i;
  always #5 i_mclk = ~i_mclk;
  hsr_ctrl u_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_disable_n_input(i_disable_n_input),
    .i_boost_level_strap(i_boost_level_strap),
    .i_pullup_seen(i_pullup_seen), .i_disconnect_seen(i_disconnect_seen),
    .i_fixture_seen(i_fixture_seen),
    .i_test_packet_seen(i_test_packet_seen), .i_squelch(i_squelch),
    .i_bus_reset(i_bus_reset), .i_line_state(i_line_state),
    .o_attach_flag(o_attach_flag), .o_attach_flag_oe_n(o_attach_flag_oe_n),
    .o_hs_active_flag(o_hs_active_flag),
    .o_hs_active_flag_oe_n(o_hs_active_flag_oe_n),
    .o_comp_enable(o_comp_enable), .o_edge_boost(o_edge_boost),
    .o_dc_boost(o_dc_boost), .o_ready(o_ready));
  hsr_usb_peer u_peer (.i_mclk(i_mclk), .o_squelch(i_squelch),
    .o_bus_reset(i_bus_reset), .o_line_state(i_line_state));
  function [16:0] lfsr(input [16:0] v);
    lfsr = {v[15:0], v[16] ^ v[13]};
  endfunction
  task cyc(input integer n);
    repeat (n) @(posedge i_mclk);
  endtask
  task check(input [8:0] got, input [8:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Note: {attach oe_n, hs oe_n, attach, hs, comp, edge, dc}
  task expect_st(input [8:0] e);
    q.push_back(e);
    smp <= 1'h1;
    cyc(1);
    smp <= 1'h0;
    cyc(1);
  endtask
  always @(negedge i_mclk) if (smp) check({o_attach_flag_oe_n,
    o_hs_active_flag_oe_n, o_attach_flag, o_hs_active_flag,
    o_comp_enable, o_edge_boost, o_dc_boost}, q.pop_front());
  task wait_rdy;
    for (i = 0; i < 600 && o_ready !== 1'h1; i = i + 1) cyc(1);
    check({8'h00, o_ready}, 9'h001);
    cyc(2);
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    cyc(4);
    i_sys_rst <= 1'h0;
    r = lfsr(r);
    lvl = r[1:0];
    i_boost_level_strap <= lvl;
    cyc(2);
    expect_st(9'h180);
    cyc(30000);
    i_disable_n_input <= 1'h1;
    cyc(1);
    // Late strap change must not reach the boost outputs
    i_boost_level_strap <= ~lvl;
    wait_rdy;
    expect_st(9'h000);
    i_pullup_seen <= 1'h1;
    cyc(1);
    expect_st(9'h040);
    i_pullup_seen <= 1'h0;
    i_disconnect_seen <= 1'h1;
    cyc(1);
    expect_st(9'h000);
    i_disconnect_seen <= 1'h0;
    i_pullup_seen <= 1'h1;
    cyc(2);
    r = lfsr(r);
    u_peer.chirp(1900 + r[9:0], 12700 - r[9:0]);
    expect_st({5'h07, lvl, lvl});
    i_disable_n_input <= 1'h0;
    cyc(2);
    expect_st(9'h180);
    cyc(10000);
    i_disable_n_input <= 1'h1;
    wait_rdy;
    // Toggled disable re-latches the strap, now the inverted level
    expect_st({5'h03, ~lvl, ~lvl});
    i_disable_n_input <= 1'h0;
    i_pullup_seen <= 1'h0;
    i_boost_level_strap <= 2'h3;
    cyc(20);
    i_disable_n_input <= 1'h1;
    wait_rdy;
    i_fixture_seen <= 1'h1;
    cyc(2);
    i_test_packet_seen <= 1'h1;
    cyc(2);
    expect_st({5'h03, 2'h3, 2'h3});
    print_verdict;
  end
  initial begin
    cyc(90000);
    failures = failures + 1;
    print_verdict;
  end
endmodule // test_hsr_ctrl
